// ===== pss_consts.svh
// constants for the packet stream slave port: reset values and fifo defaults
// included by the package and the design modules by bare name
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_DATA_W 64
`define PSS_DEPTH 16
`define PSS_THRESHOLD 4
`define PSS_PAR_ODD 1'H0
`define PSS_RST_BIT 1'H0
`define PSS_MTY_ZERO 3'H0
`define PSS_MTY_W64 3
`define PSS_MTY_W32 2
`define PSS_MTY_WMIN 1

`endif

// ===== pss_pkg.sv
// types for the packet stream slave port
// assumes pss_consts.svh is on the include path
package pss_pkg;
  `include "pss_consts.svh"

  // sink-side packet tracking
  typedef enum logic [1:0] {
    PSS_IDLE  = 2'H0,
    PSS_BODY  = 2'H1,
    PSS_TRUNC = 2'H2,
    PSS_SKIP  = 2'H3
  } pss_rx_state_type;
endpackage

// ===== pss_fifo.sv
// word store of the packet stream slave port: synchronous fifo, show-ahead head
// assumes the caller never writes when full nor reads when empty
`timescale 1ns/10ps
`include "pss_consts.svh"
module pss_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = `PSS_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic [CNT_W-1:0] count
);
  import pss_pkg::*;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (wr_en) begin
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'H1);
    end
    if (rd_en) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'H1);
    end
    if (wr_en && !rd_en) begin
      next_count = CNT_W'(count + 1'H1);
    end else if (rd_en && !wr_en) begin
      next_count = CNT_W'(count - 1'H1);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset so it maps onto plain ram
  always_ff @(posedge SYS_CLK) begin
    if (wr_en) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_ptr];
endmodule

// ===== pss_port.sv
// packet stream slave port: slave sink that checks and stores packets, slave source that serves them
// assumes both masters run on SYS_CLK; master pins are already in this clock domain
//
// Contract
// R1: word bus width is 8, 16, 32 or 64 bits, same on both ends.
// R2: synchronous point-to-point, unidirectional buses, both directions at once.
// R3: as slave sink, accept master writes and store words like a fifo.
// R4: master sink issues read enables only when it needs data.
// R5: octets big-endian, valid bytes packed from the most significant end.
// R6: optional parity bit over whole word, odd or even selectable.
// R7: first-word flag on exactly the first transfer of each packet.
// R8: last-word flag on exactly the last transfer of each packet.
// R9: abort flag high means receiver discards the whole packet.
// R10: abort may rise anywhere, stays high, falls only after last word.
// R11: receive path raises abort on overflow, abort, missing markers, parity error; overflow at a packet's first word drops the whole packet without abort.
// R12: empty count gives invalid low-order bytes of last word, eight bits each.
// R13: empty count width: none, 1, 2, 3 bits for 8/16/32/64; the code gives 8 bits a 1-bit count held at zero.
// R14: empty count is zero on every transfer without last-word flag.
// R15: master alone drives enable; slave captures writes on enable-high edge.
// R16: slave source drives next word and valid the edge after enable.
// R17: valid and data change only after enable sampled high, else hold.
// R18: fill indicator shows threshold words or packet end, or threshold room.
// R19: parity sense is a shared build parameter and covers all word bits.
`timescale 1ns/10ps
`include "pss_consts.svh"
module pss_port #(
  parameter int DATA_W = `PSS_DATA_W, // R1
  parameter int DEPTH = `PSS_DEPTH,
  parameter int THRESHOLD = `PSS_THRESHOLD,
  parameter logic PAR_ODD = `PSS_PAR_ODD,
  parameter int MTY_W = (DATA_W == 64) ? `PSS_MTY_W64 : (DATA_W == 32) ? `PSS_MTY_W32 : `PSS_MTY_WMIN
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SNK_ENA,
  input wire logic [DATA_W-1:0] SNK_DAT,
  input wire logic SNK_PAR,
  input wire logic SNK_SOP,
  input wire logic SNK_EOP,
  input wire logic SNK_ERR,
  input wire logic [MTY_W-1:0] SNK_MTY,
  output logic SNK_DAV,
  input wire logic SRC_ENA,
  output logic [DATA_W-1:0] SRC_DAT,
  output logic SRC_PAR,
  output logic SRC_SOP,
  output logic SRC_EOP,
  output logic SRC_ERR,
  output logic [MTY_W-1:0] SRC_MTY,
  output logic SRC_VAL,
  output logic SRC_DAV
);
  import pss_pkg::*;
  localparam int WORD_W = DATA_W + MTY_W + 3;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // stored word layout: {err, eop, sop, mty, dat}
  logic wr_en;
  logic [WORD_W-1:0] wr_word;
  logic rd_en;
  logic [WORD_W-1:0] head;
  logic [CNT_W-1:0] count;
  logic empty;

  pss_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_store (
    .SYS_CLK(SYS_CLK),
    .NRST(NRST),
    .wr_en(wr_en),
    .wr_data(wr_word),
    .rd_en(rd_en),
    .rd_data(head),
    .count(count)
  );

  assign empty = (count == '0);

  // ---------------- sink side ----------------
  pss_rx_state_type state;
  pss_rx_state_type next_state;
  logic err_hold;
  logic next_err_hold;
  logic par_bad;
  logic bad;
  logic w_sop;
  logic w_err;
  logic [MTY_W-1:0] w_mty;
  logic last_free;
  logic full;
  logic mty_used;

  assign full = (count == CNT_W'(DEPTH));
  // one slot is kept back so a truncated packet can still close with its last word
  assign last_free = (count >= CNT_W'(DEPTH - 1));
  assign mty_used = (DATA_W != 8);

  always_comb begin
    par_bad = ((^SNK_DAT) ^ SNK_PAR) != PAR_ODD; // R6 R19
    bad = par_bad || SNK_ERR; // R11
    w_sop = SNK_SOP;
    wr_en = 1'H0;
    next_state = state;
    next_err_hold = err_hold;
    case (state)
      PSS_IDLE: begin
        if (!SNK_SOP) begin
          bad = 1'H1; // R11
          w_sop = 1'H1; // R7
        end
        if (SNK_ENA) begin
          if (full && SNK_EOP) begin
            next_state = PSS_IDLE;
          end else if (last_free && !SNK_EOP) begin
            next_state = PSS_SKIP; // R9
          end else begin
            wr_en = 1'H1; // R3
            next_state = SNK_EOP ? PSS_IDLE : PSS_BODY;
          end
        end
      end
      PSS_BODY: begin
        if (SNK_SOP) begin
          // a new start inside a packet means the old end went missing: merge and abort
          bad = 1'H1; // R11
          w_sop = 1'H0; // R7
        end
        if (SNK_ENA) begin
          if (last_free && !SNK_EOP) begin
            next_state = PSS_TRUNC; // R11
            next_err_hold = 1'H1;
          end else begin
            wr_en = 1'H1; // R3
            next_state = SNK_EOP ? PSS_IDLE : PSS_BODY;
          end
        end
      end
      PSS_TRUNC: begin
        w_sop = 1'H0;
        bad = 1'H1;
        if (SNK_ENA && SNK_EOP) begin
          wr_en = 1'H1; // R8
          next_state = PSS_IDLE;
        end
      end
      PSS_SKIP: begin
        w_sop = 1'H0;
        if (SNK_ENA && SNK_EOP) begin
          next_state = PSS_IDLE;
        end
      end
      default: begin
        next_state = PSS_IDLE;
      end
    endcase
    w_err = err_hold || bad; // R10
    if (SNK_ENA && wr_en) begin
      next_err_hold = SNK_EOP ? 1'H0 : w_err; // R10
    end
    w_mty = (SNK_EOP && mty_used) ? SNK_MTY : '0; // R12 R13 R14
    wr_word = {w_err, SNK_EOP, w_sop, w_mty, SNK_DAT}; // R5
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state <= PSS_IDLE;
      err_hold <= `PSS_RST_BIT;
    end else begin
      state <= next_state; // R15
      err_hold <= next_err_hold;
    end
  end

  // ---------------- fill levels ----------------
  logic [CNT_W-1:0] eop_count;
  logic [CNT_W-1:0] next_eop_count;
  logic next_snk_dav;
  logic next_src_dav;

  always_comb begin
    next_eop_count = eop_count;
    if (wr_en && SNK_EOP && !(rd_en && head[WORD_W-2])) begin
      next_eop_count = CNT_W'(eop_count + 1'H1);
    end else if (rd_en && head[WORD_W-2] && !(wr_en && SNK_EOP)) begin
      next_eop_count = CNT_W'(eop_count - 1'H1);
    end
    // registered from current levels, so the flags trail the store by one cycle
    next_src_dav = (count >= CNT_W'(THRESHOLD)) || (eop_count != '0); // R18
    next_snk_dav = (CNT_W'(DEPTH) - count) >= CNT_W'(THRESHOLD); // R18
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      eop_count <= '0;
      SRC_DAV <= `PSS_RST_BIT;
      SNK_DAV <= `PSS_RST_BIT;
    end else begin
      eop_count <= next_eop_count;
      SRC_DAV <= next_src_dav;
      SNK_DAV <= next_snk_dav;
    end
  end

  // ---------------- source side ----------------
  logic [DATA_W-1:0] next_dat;
  logic next_par;
  logic next_sop;
  logic next_eop;
  logic next_err;
  logic [MTY_W-1:0] next_mty;
  logic next_val;

  // the source bus runs on its own, alongside the sink bus
  assign rd_en = SRC_ENA && !empty; // R16 R2

  always_comb begin
    next_dat = SRC_DAT;
    next_par = SRC_PAR;
    next_sop = SRC_SOP;
    next_eop = SRC_EOP;
    next_err = SRC_ERR;
    next_mty = SRC_MTY;
    next_val = SRC_VAL;
    if (SRC_ENA) begin
      next_val = !empty; // R16 R17
      if (!empty) begin
        next_dat = head[DATA_W-1:0]; // R5
        next_mty = head[DATA_W+MTY_W-1:DATA_W]; // R14
        next_sop = head[WORD_W-3]; // R7
        next_eop = head[WORD_W-2]; // R8
        next_err = head[WORD_W-1]; // R9 R10
        next_par = (^head[DATA_W-1:0]) ^ PAR_ODD; // R6 R19
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      SRC_DAT <= '0;
      SRC_PAR <= PAR_ODD;
      SRC_SOP <= `PSS_RST_BIT;
      SRC_EOP <= `PSS_RST_BIT;
      SRC_ERR <= `PSS_RST_BIT;
      SRC_MTY <= '0;
      SRC_VAL <= `PSS_RST_BIT;
    end else begin
      SRC_DAT <= next_dat; // R17
      SRC_PAR <= next_par;
      SRC_SOP <= next_sop;
      SRC_EOP <= next_eop;
      SRC_ERR <= next_err;
      SRC_MTY <= next_mty;
      SRC_VAL <= next_val;
    end
  end
endmodule

// ===== pss_port_chk.sv
// checker for the slave source side of the packet stream port
// assumes a 64-bit word bus and the port's own parity sense
`timescale 1ns/10ps
module pss_port_chk #(
  parameter int MTY_W = 3,
  parameter logic PAR_ODD = 1'H0
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SRC_ENA,
  input wire logic [63:0] SRC_DAT,
  input wire logic SRC_PAR,
  input wire logic SRC_SOP,
  input wire logic SRC_EOP,
  input wire logic SRC_ERR,
  input wire logic [MTY_W-1:0] SRC_MTY,
  input wire logic SRC_VAL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  property p_hold;
    !SRC_ENA |=> $stable(SRC_DAT) && $stable(SRC_VAL) && $stable(SRC_EOP);
  endproperty
  a_hold: assert property (p_hold) else $error("source word changed without enable");
  property p_par;
    SRC_VAL |-> ((^SRC_DAT) ^ SRC_PAR) == PAR_ODD;
  endproperty
  a_par: assert property (p_par) else $error("source parity wrong");
  property p_mty;
    !SRC_EOP |-> SRC_MTY == '0;
  endproperty
  a_mty: assert property (p_mty) else $error("empty count set without last word");
  property p_err;
    SRC_VAL && SRC_ERR && !SRC_EOP |=> SRC_ERR;
  endproperty
  a_err: assert property (p_err) else $error("abort dropped inside packet");
  property p_fall;
    $fell(SRC_ERR) |-> $past(SRC_EOP);
  endproperty
  a_fall: assert property (p_fall) else $error("abort fell not after last word");
  property p_rise;
    $rose(SRC_VAL) |-> $past(SRC_ENA);
  endproperty
  a_rise: assert property (p_rise) else $error("valid rose without enable");
  property p_sop;
    SRC_ENA && SRC_VAL && SRC_SOP && !SRC_EOP |=> !(SRC_VAL && SRC_SOP);
  endproperty
  a_sop: assert property (p_sop) else $error("second first-word flag");
  property p_eop;
    SRC_ENA && SRC_VAL && SRC_EOP |=> !SRC_VAL || SRC_SOP;
  endproperty
  a_eop: assert property (p_eop) else $error("word after last word not a start");
endmodule
bind pss_port pss_port_chk #(.MTY_W(MTY_W), .PAR_ODD(PAR_ODD)) chk (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .SRC_ENA(SRC_ENA), .SRC_DAT(SRC_DAT), .SRC_PAR(SRC_PAR), .SRC_SOP(SRC_SOP), .SRC_EOP(SRC_EOP),
  .SRC_ERR(SRC_ERR), .SRC_MTY(SRC_MTY), .SRC_VAL(SRC_VAL));

// ===== pss_sink_model.sv
// master sink model: reads the slave source when it reports data
// assumes a 64-bit bus; received words queue as err, sop, eop, mty, dat
`timescale 1ns/10ps
module pss_sink_model (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic run,
  input wire logic stall,
  input wire logic SRC_DAV,
  input wire logic SRC_VAL,
  input wire logic SRC_SOP,
  input wire logic SRC_EOP,
  input wire logic SRC_ERR,
  input wire logic [2:0] SRC_MTY,
  input wire logic [63:0] SRC_DAT,
  output logic SRC_ENA
);
  logic prev_ena;
  logic skip;
  logic [69:0] rx_q[$];
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      SRC_ENA <= 1'H0;
      prev_ena <= 1'H0;
      skip <= 1'H0;
    end else begin
      skip <= stall && !skip;
      // reads only when data is reported, so it may also read a drained store
      SRC_ENA <= run && SRC_DAV && !(stall && !skip);
      prev_ena <= SRC_ENA;
      if (prev_ena && SRC_VAL) begin
        rx_q.push_back({SRC_ERR, SRC_SOP, SRC_EOP, SRC_MTY, SRC_DAT});
      end
    end
  end
endmodule

// ===== pss_port_bench.sv
// self-checking bench for the packet stream port, 64-bit bus, even parity
// assumes the sink model above reads the source side
`timescale 1ns/10ps
module pss_port_bench;
  import pss_pkg::*;
  logic sys_clk = 1'H0;
  logic nrst = 1'H0;
  logic ena = 1'H0, par = 1'H0, sop = 1'H0, eop = 1'H0, err = 1'H0, run = 1'H0, stall = 1'H0;
  logic [63:0] dat = 64'H0;
  logic [2:0] mty = 3'H0;
  logic src_ena, val, o_par, o_sop, o_eop, o_err, snk_dav, src_dav;
  logic [63:0] o_dat;
  logic [2:0] o_mty;
  int mismatches = 0;
  int total_checks = 0;
  always #4 sys_clk = !sys_clk;
  pss_port uut (.SYS_CLK(sys_clk), .NRST(nrst), .SNK_ENA(ena), .SNK_DAT(dat), .SNK_PAR(par), .SNK_SOP(sop),
    .SNK_EOP(eop), .SNK_ERR(err), .SNK_MTY(mty), .SNK_DAV(snk_dav), .SRC_ENA(src_ena), .SRC_DAT(o_dat),
    .SRC_PAR(o_par), .SRC_SOP(o_sop), .SRC_EOP(o_eop), .SRC_ERR(o_err), .SRC_MTY(o_mty), .SRC_VAL(val),
    .SRC_DAV(src_dav));
  pss_sink_model sink (.SYS_CLK(sys_clk), .NRST(nrst), .run(run), .stall(stall), .SRC_DAV(src_dav),
    .SRC_VAL(val), .SRC_SOP(o_sop), .SRC_EOP(o_eop), .SRC_ERR(o_err), .SRC_MTY(o_mty), .SRC_DAT(o_dat),
    .SRC_ENA(src_ena));
  task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bad flips the parity bit so the word fails its check
  task automatic wr(input logic s, input logic e, input logic [2:0] m, input logic [7:0] b, input logic bad);
    @(posedge sys_clk);
    ena <= 1'H1;
    sop <= s;
    eop <= e;
    mty <= m;
    dat <= {8{b}};
    par <= (^{8{b}}) ^ bad;
    @(posedge sys_clk);
    ena <= 1'H0;
  endtask
  task automatic rd(input logic e, input logic s, input logic p, input logic [2:0] m, input logic [7:0] b);
    int n;
    for (n = 0; n < 300 && sink.rx_q.size() == 0; n++) @(posedge sys_clk);
    if (sink.rx_q.size() == 0) chk(70'H0, 70'H1);
    else chk(sink.rx_q.pop_front(), {e, s, p, m, {8{b}}});
  endtask
  task automatic t_plain;
    run <= 1'H1;
    stall <= 1'H1;
    wr(1, 0, 0, 8'HA1, 0);
    wr(0, 0, 0, 8'HB2, 0);
    wr(0, 1, 2, 8'HC3, 0);
    rd(0, 1, 0, 0, 8'HA1);
    rd(0, 0, 0, 0, 8'HB2);
    rd(0, 0, 1, 2, 8'HC3);
  endtask
  task automatic t_parity;
    stall <= 1'H0;
    wr(1, 0, 0, 8'H11, 0);
    wr(0, 0, 0, 8'H22, 1);
    wr(0, 1, 0, 8'H33, 0);
    rd(0, 1, 0, 0, 8'H11);
    rd(1, 0, 0, 0, 8'H22);
    rd(1, 0, 1, 0, 8'H33);
    wr(0, 1, 1, 8'H44, 0);
    rd(1, 1, 1, 1, 8'H44);
  endtask
  task automatic t_marks;
    wr(1, 0, 0, 8'H55, 0);
    wr(1, 0, 0, 8'H66, 0);
    wr(0, 1, 0, 8'H77, 0);
    err <= 1'H1;
    wr(1, 1, 0, 8'H88, 0);
    err <= 1'H0;
    rd(0, 1, 0, 0, 8'H55);
    rd(1, 0, 0, 0, 8'H66);
    rd(1, 0, 1, 0, 8'H77);
    rd(1, 1, 1, 0, 8'H88);
  endtask
  task automatic t_overflow;
    int i;
    run <= 1'H0;
    for (i = 0; i < 17; i++) wr(i == 0, 0, 0, 8'(i), 0);
    wr(0, 1, 0, 8'HEE, 0);
    // store is full now: both packets below must vanish
    wr(1, 0, 0, 8'H99, 0);
    wr(0, 1, 0, 8'H9A, 0);
    wr(1, 1, 0, 8'H9B, 0);
    repeat (2) @(posedge sys_clk);
    chk({snk_dav, src_dav}, 2'H1);
    run <= 1'H1;
    for (i = 0; i < 15; i++) rd(0, i == 0, 0, 0, 8'(i));
    rd(1, 0, 1, 0, 8'HEE);
    repeat (4) @(posedge sys_clk);
    chk({snk_dav, src_dav, val}, 3'H4);
    chk(sink.rx_q.size(), 0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'H1;
    t_plain();
    t_parity();
    t_marks();
    t_overflow();
    report_and_stop();
  end
  initial begin
    #(20000 * 8);
    mismatches++;
    report_and_stop();
  end
endmodule
